// ===== rtl/dpca_pkg.sv
// constants and types shared by the control-access block
// assumes one core clock; all counts are in core clock cycles
package dpca_pkg;
   ////////////////////////////////////////////////////////////////////////
   // synchronised pin vector {mode, wr_n, rd_n, cs_n, a[2:0], d[7:0]}
   localparam int          PIN_W          = 15;
   localparam logic [14:0] PIN_RST        = 15'h3800;
   ////////////////////////////////////////////////////////////////////////
   // interface register addresses
   localparam logic [2:0]  XA_DATA0       = 3'h0;
   localparam logic [2:0]  XA_DATA1       = 3'h1;
   localparam logic [2:0]  XA_DATA2       = 3'h2;
   localparam logic [2:0]  XA_DATA3       = 3'h3;
   localparam logic [2:0]  XA_DATA4       = 3'h4;
   localparam logic [2:0]  XA_RSVD        = 3'h5;
   localparam logic [2:0]  XA_LOW_ADDR    = 3'h6;
   localparam logic [2:0]  XA_MODE_CTRL   = 3'h7;
   // address mode control fields
   localparam int          MC_RD_INC      = 6;
   localparam int          MC_WR_INC      = 7;
   localparam logic [7:0]  MC_KEEP_MASK   = 8'hC3;
   localparam logic [7:0]  MC_RESET       = 8'h00;
   localparam logic [7:0]  LOW_ADDR_RESET = 8'h00;
   localparam logic [7:0]  BYTE_RESET     = 8'h00;
   localparam logic [3:0]  NIB_RESET      = 4'h0;
   localparam logic [9:0]  ADDR_STEP      = 10'h001;
   ////////////////////////////////////////////////////////////////////////
   // microport answer edges counted from the accepting edge N
   localparam logic [1:0]  CNT_ONE        = 2'h1;
   localparam logic [1:0]  CNT_FAST       = 2'h2;
   localparam logic [1:0]  CNT_SLOW       = 2'h3;
   ////////////////////////////////////////////////////////////////////////
   // serial command word fields
   localparam int          SC_RD_BIT      = 15;
   localparam int          SC_WR_BIT      = 14;
   localparam logic [2:0]  SC_READS_MAX   = 3'h4;
   localparam logic [31:0] SC_WORD_RESET  = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      MP_IDLE = 2'b00,
      MP_BUSY = 2'b01,
      MP_DONE = 2'b10
   } dpca_mp_t;
   typedef enum logic [1:0] {
      EN_IDLE = 2'b00,
      EN_OP   = 2'b01,
      EN_RET  = 2'b10
   } dpca_en_t;
   typedef enum logic {
      SP_IDLE = 1'b0,
      SP_REQ  = 1'b1
   } dpca_sp_t;
endpackage

// ===== rtl/dpca_acc_if.sv
// request and answer between serial decoder and register engine
// assumes both ends on the core clock
`timescale 1ns/1ps
interface dpca_acc_if;
   logic       req;
   logic       we;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       done;
   modport ser (output req, we, addr, wdata, input rdata, done);
   modport eng (input req, we, addr, wdata, output rdata, done);
endinterface

// ===== rtl/dpca_sync.sv
// three-stage synchroniser for the microport pins
// output follows once stages two and three agree
`timescale 1ns/1ps
module dpca_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_q;

   always_comb begin
      next_q = (s2 == s3) ? s3 : q_out;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1    <= RST_VAL;
         s2    <= RST_VAL;
         s3    <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         s1    <= d_in;
         s2    <= s1;
         s3    <= s2;
         q_out <= next_q;
      end
   end
endmodule

// ===== rtl/dpca_serial_dec.sv
// serial command decoder: one register access per command word
// assumes words arrive as one-cycle strobes from the framing logic
`timescale 1ns/1ps
module dpca_serial_dec
   import dpca_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] command_in,
   input  wire logic        command_valid_in,
   input  wire logic        frame_start_in,
   output logic      [31:0] rdata_word_out,
   output logic      [2:0]  reads_out,
   output logic             busy_out,
   dpca_acc_if.ser          acc
);
   dpca_sp_t    sp;
   dpca_sp_t    next_sp;
   logic        we;
   logic        next_we;
   logic [2:0]  addr;
   logic [2:0]  next_addr;
   logic [7:0]  wdata;
   logic [7:0]  next_wdata;
   logic [31:0] next_word;
   logic [2:0]  next_reads;

   assign acc.req   = (sp == SP_REQ);
   assign acc.we    = we;
   assign acc.addr  = addr;
   assign acc.wdata = wdata;
   assign busy_out  = (sp == SP_REQ);

   always_comb begin
      next_sp    = sp;
      next_we    = we;
      next_addr  = addr;
      next_wdata = wdata;
      next_word  = rdata_word_out;
      next_reads = reads_out;
      if (frame_start_in) begin
         next_word  = SC_WORD_RESET;
         next_reads = 3'h0;
      end
      unique case (sp)
         SP_IDLE: begin
            // words that carry neither flag make no access
            if (command_valid_in &&
                (command_in[SC_RD_BIT] || command_in[SC_WR_BIT])) begin
               next_sp    = SP_REQ;
               next_we    = !command_in[SC_RD_BIT];
               next_addr  = command_in[10:8];
               next_wdata = command_in[7:0];
            end
         end
         SP_REQ: begin
            if (acc.done) begin
               next_sp = SP_IDLE;
               if (!we && next_reads < SC_READS_MAX) begin
                  // first read lands in the top byte
                  case (next_reads)
                     3'h0:    next_word[31:24] = acc.rdata;
                     3'h1:    next_word[23:16] = acc.rdata;
                     3'h2:    next_word[15:8]  = acc.rdata;
                     default: next_word[7:0]   = acc.rdata;
                  endcase
                  next_reads = next_reads + 3'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sp             <= SP_IDLE;
         we             <= 1'b0;
         addr           <= 3'h0;
         wdata          <= BYTE_RESET;
         rdata_word_out <= SC_WORD_RESET;
         reads_out      <= 3'h0;
      end else begin
         sp             <= next_sp;
         we             <= next_we;
         addr           <= next_addr;
         wdata          <= next_wdata;
         rdata_word_out <= next_word;
         reads_out      <= next_reads;
      end
   end

   a_first_read_top : assert property (@(posedge clk_in) disable iff (rst_in)
      sp == SP_REQ && acc.done && !we && !frame_start_in && reads_out == 3'h0
      |=> rdata_word_out[31:24] == $past(acc.rdata))
      else $error("first serial read not in top byte");
   a_one_access : assert property (@(posedge clk_in) disable iff (rst_in)
      sp == SP_REQ && acc.done |=> !acc.req)
      else $error("serial word made more than one access");
endmodule

// ===== rtl/dpca_top.sv
// control access: microport and serial decoder share the interface regs
// assumes internal read data is valid while INT_RD_OUT is high
`timescale 1ns/1ps
module dpca_top
   import dpca_pkg::*;
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        MODE_IN,
   input  wire logic        CS_N_IN,
   input  wire logic        RD_N_IN,
   input  wire logic        WR_N_IN,
   input  wire logic [2:0]  A_IN,
   input  wire logic [7:0]  D_IN,
   output logic      [7:0]  D_OUT,
   output logic             D_OE_N_OUT,
   output logic             READY_OUT,
   output logic             TRANSFER_ACK_N_OUT,
   input  wire logic [15:0] SERIAL_COMMAND_IN,
   input  wire logic        SERIAL_COMMAND_VALID_IN,
   input  wire logic        SERIAL_FRAME_START_IN,
   output logic      [31:0] SERIAL_RDATA_OUT,
   output logic      [2:0]  SERIAL_READS_OUT,
   output logic             SERIAL_BUSY_OUT,
   output logic      [9:0]  INT_ADDR_OUT,
   output logic      [35:0] INT_WDATA_OUT,
   output logic             INT_WR_OUT,
   output logic             INT_RD_OUT,
   input  wire logic [35:0] INT_RDATA_IN
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation and strobe decode
   logic [PIN_W-1:0] pins_s;
   logic             mode_s;
   logic             wr_n_s;
   logic             rd_n_s;
   logic             cs_n_s;
   logic [2:0]       a_s;
   logic [7:0]       d_s;
   logic             s_rd;
   logic             s_wr;
   logic             raw_act;

   dpca_sync #(
      .W       (PIN_W),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .clk_in (CORE_CLK_IN),
      .rst_in (RST_IN),
      .d_in   ({MODE_IN, WR_N_IN, RD_N_IN, CS_N_IN, A_IN, D_IN}),
      .q_out  (pins_s)
   );

   assign {mode_s, wr_n_s, rd_n_s, cs_n_s, a_s, d_s} = pins_s;
   // mode 1: read pin strobes, write pin high means read
   assign s_rd = !cs_n_s && (mode_s ? (!rd_n_s && wr_n_s) : !rd_n_s);
   assign s_wr = !cs_n_s && (mode_s ? (!rd_n_s && !wr_n_s) : !wr_n_s);
   assign raw_act = !CS_N_IN && (!RD_N_IN || !WR_N_IN);

   ////////////////////////////////////////////////////////////////////////
   // shared interface registers and arbitration
   dpca_acc_if acc ();

   dpca_mp_t        mp_state;
   dpca_mp_t        next_mp_state;
   logic [1:0]      mp_cnt;
   logic [1:0]      next_mp_cnt;
   logic [1:0]      mp_tgt;
   logic [1:0]      next_mp_tgt;
   logic            mp_we;
   logic            next_mp_we;
   logic [2:0]      mp_addr;
   logic [2:0]      next_mp_addr;
   logic [7:0]      next_d_out;
   logic            next_d_oe_n;
   dpca_en_t        ser_ph;
   dpca_en_t        next_ser_ph;
   logic [7:0]      ser_rdata;
   logic [7:0]      next_ser_rdata;
   logic            ser_done;
   logic            next_ser_done;
   logic [3:0][7:0] data_byte;
   logic [3:0][7:0] next_data_byte;
   logic [3:0]      data_byte_four;
   logic [3:0]      next_data_byte_four;
   logic [7:0]      low_addr;
   logic [7:0]      next_low_addr;
   logic [7:0]      addr_mode;
   logic [7:0]      next_addr_mode;
   logic            int_rd;
   logic            next_int_rd;
   logic            int_wr;
   logic            next_int_wr;
   logic            int_busy;
   logic            ser_go;
   logic            mp_go;
   logic            op_go;
   logic            op_we;
   logic [2:0]      op_addr;
   logic [7:0]      op_wdata;
   logic [7:0]      rd_view [8];

   function automatic logic [9:0] addr_step(input logic [9:0] a);
      return a + ADDR_STEP;
   endfunction

   assign acc.rdata          = ser_rdata;
   assign acc.done           = ser_done;
   assign INT_ADDR_OUT       = {addr_mode[1:0], low_addr};
   assign INT_WDATA_OUT      = {data_byte_four, data_byte[3], data_byte[2],
                                data_byte[1], data_byte[0]};
   assign INT_WR_OUT         = int_wr;
   assign INT_RD_OUT         = int_rd;
   assign int_busy           = int_rd || int_wr;
   assign READY_OUT          = MODE_IN || !raw_act ||
                               (mp_state == MP_DONE);
   assign TRANSFER_ACK_N_OUT = !(MODE_IN && mp_state == MP_DONE &&
                                 !CS_N_IN && !RD_N_IN);

   always_comb begin
      rd_view[0] = data_byte[0];
      rd_view[1] = data_byte[1];
      rd_view[2] = data_byte[2];
      rd_view[3] = data_byte[3];
      rd_view[4] = {4'h0, data_byte_four};
      rd_view[5] = BYTE_RESET;
      rd_view[6] = low_addr;
      rd_view[7] = addr_mode;
   end

   always_comb begin
      ser_go   = acc.req && !acc.done && ser_ph == EN_IDLE && !int_busy;
      mp_go    = mp_state == MP_IDLE && (s_rd || s_wr) && !acc.req &&
                 !acc.done && ser_ph == EN_IDLE && !int_busy;
      op_go    = ser_go || mp_go;
      op_we    = ser_go ? acc.we : s_wr;
      op_addr  = ser_go ? acc.addr : a_s;
      op_wdata = ser_go ? acc.wdata : d_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // register engine: byte access, internal fetch and push, increment
   always_comb begin
      next_data_byte      = data_byte;
      next_data_byte_four = data_byte_four;
      next_low_addr       = low_addr;
      next_addr_mode      = addr_mode;
      next_int_rd         = 1'b0;
      next_int_wr         = 1'b0;
      next_ser_ph         = ser_ph;
      next_ser_rdata      = ser_rdata;
      next_ser_done       = 1'b0;
      if (op_go && op_we) begin
         case (op_addr)
            XA_DATA0: begin
               next_data_byte[0] = op_wdata;
               next_int_wr       = 1'b1;
            end
            XA_DATA1, XA_DATA2, XA_DATA3:
               next_data_byte[op_addr[1:0]] = op_wdata;
            XA_DATA4:     next_data_byte_four = op_wdata[3:0];
            XA_LOW_ADDR:  next_low_addr = op_wdata;
            XA_MODE_CTRL: next_addr_mode = op_wdata & MC_KEEP_MASK;
            default: ;
         endcase
      end else if (op_go && op_addr == XA_DATA0) begin
         next_int_rd = 1'b1;
      end
      if (int_rd) begin
         next_data_byte      = INT_RDATA_IN[31:0];
         next_data_byte_four = INT_RDATA_IN[35:32];
      end
      if ((int_rd && addr_mode[MC_RD_INC]) ||
          (int_wr && addr_mode[MC_WR_INC])) begin
         {next_addr_mode[1:0], next_low_addr} = addr_step(INT_ADDR_OUT);
      end
      unique case (ser_ph)
         EN_IDLE: if (ser_go) next_ser_ph = EN_OP;
         EN_OP:   next_ser_ph = EN_RET;
         EN_RET: begin
            next_ser_rdata = rd_view[acc.addr];
            next_ser_done  = 1'b1;
            next_ser_ph    = EN_IDLE;
         end
         default: next_ser_ph = EN_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // microport handshake sequencer
   always_comb begin
      next_mp_state = mp_state;
      next_mp_cnt   = mp_cnt;
      next_mp_tgt   = mp_tgt;
      next_mp_we    = mp_we;
      next_mp_addr  = mp_addr;
      next_d_out    = D_OUT;
      unique case (mp_state)
         MP_IDLE: begin
            next_mp_tgt = (mode_s ? (s_wr || a_s == XA_DATA0) :
                                    (s_rd && a_s == XA_DATA0)) ?
                          CNT_SLOW : CNT_FAST;
            // held strobes start a new access once chip select returns
            if (mp_go) begin
               next_mp_state = MP_BUSY;
               next_mp_cnt   = CNT_ONE;
               next_mp_we    = s_wr;
               next_mp_addr  = a_s;
            end
         end
         MP_BUSY: begin
            if (mp_cnt == mp_tgt) begin
               next_mp_state = MP_DONE;
               if (!mp_we) next_d_out = rd_view[mp_addr];
            end else begin
               next_mp_cnt = mp_cnt + CNT_ONE;
            end
         end
         MP_DONE: if (cs_n_s) next_mp_state = MP_IDLE;
         default: next_mp_state = MP_IDLE;
      endcase
      // drive data only while a read is in progress
      next_d_oe_n = !(next_mp_state != MP_IDLE && !next_mp_we);
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         mp_state       <= MP_IDLE;
         mp_cnt         <= 2'h0;
         mp_tgt         <= CNT_FAST;
         mp_we          <= 1'b0;
         mp_addr        <= XA_DATA0;
         D_OUT          <= BYTE_RESET;
         D_OE_N_OUT     <= 1'b1;
         ser_ph         <= EN_IDLE;
         ser_rdata      <= BYTE_RESET;
         ser_done       <= 1'b0;
         data_byte      <= {4{BYTE_RESET}};
         data_byte_four <= NIB_RESET;
         low_addr       <= LOW_ADDR_RESET;
         addr_mode      <= MC_RESET;
         int_rd         <= 1'b0;
         int_wr         <= 1'b0;
      end else begin
         mp_state       <= next_mp_state;
         mp_cnt         <= next_mp_cnt;
         mp_tgt         <= next_mp_tgt;
         mp_we          <= next_mp_we;
         mp_addr        <= next_mp_addr;
         D_OUT          <= next_d_out;
         D_OE_N_OUT     <= next_d_oe_n;
         ser_ph         <= next_ser_ph;
         ser_rdata      <= next_ser_rdata;
         ser_done       <= next_ser_done;
         data_byte      <= next_data_byte;
         data_byte_four <= next_data_byte_four;
         low_addr       <= next_low_addr;
         addr_mode      <= next_addr_mode;
         int_rd         <= next_int_rd;
         int_wr         <= next_int_wr;
      end
   end

   dpca_serial_dec u_serial (
      .clk_in           (CORE_CLK_IN),
      .rst_in           (RST_IN),
      .command_in       (SERIAL_COMMAND_IN),
      .command_valid_in (SERIAL_COMMAND_VALID_IN),
      .frame_start_in   (SERIAL_FRAME_START_IN),
      .rdata_word_out   (SERIAL_RDATA_OUT),
      .reads_out        (SERIAL_READS_OUT),
      .busy_out         (SERIAL_BUSY_OUT),
      .acc              (acc.ser)
   );

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);

   a_fetch_issue : assert property (
      op_go && !op_we && op_addr == XA_DATA0 |=> INT_RD_OUT)
      else $error("byte zero read did not fetch");
   a_fetch_load : assert property (
      INT_RD_OUT |=> data_byte[1] == $past(INT_RDATA_IN[15:8]) &&
                     data_byte_four == $past(INT_RDATA_IN[35:32]))
      else $error("fetched word not in data bytes");
   a_inc_step : assert property (
      INT_RD_OUT && addr_mode[MC_RD_INC]
      |=> INT_ADDR_OUT == addr_step($past(INT_ADDR_OUT)))
      else $error("address did not step after read");
   a_no_step : assert property (
      (INT_RD_OUT && !addr_mode[MC_RD_INC]) ||
      (INT_WR_OUT && !addr_mode[MC_WR_INC]) |=> $stable(INT_ADDR_OUT))
      else $error("address stepped when disabled");
   a_fast_done : assert property (
      mp_go && next_mp_tgt == CNT_FAST
      |=> (mp_state != MP_DONE)[*2] ##1 mp_state == MP_DONE)
      else $error("fast answer not at N+2");
   a_slow_done : assert property (
      mp_go && next_mp_tgt == CNT_SLOW
      |=> (mp_state != MP_DONE)[*3] ##1 mp_state == MP_DONE)
      else $error("slow answer not at N+3");
   a_serial_first : assert property (
      acc.req && !acc.done && ser_ph == EN_IDLE && !int_busy &&
      mp_state == MP_IDLE && (s_rd || s_wr)
      |=> ser_ph == EN_OP && mp_state == MP_IDLE)
      else $error("microport won over serial");
   a_stall_ready : assert property (
      !MODE_IN && raw_act && ser_ph != EN_IDLE |-> !READY_OUT)
      else $error("ready high during serial access");
   a_ack_wait : assert property (
      mp_state == MP_IDLE |-> TRANSFER_ACK_N_OUT)
      else $error("acknowledge before access done");
   a_push_word : assert property (
      op_go && op_we && op_addr == XA_DATA0
      |=> INT_WR_OUT && INT_WDATA_OUT[7:0] == $past(op_wdata))
      else $error("byte zero write did not push");
   a_mode_mask : assert property (
      op_go && op_we && op_addr == XA_MODE_CTRL
      |=> addr_mode == ($past(op_wdata) & MC_KEEP_MASK))
      else $error("mode control write wrong");

   c_mode0_read : cover property (!mode_s && mp_state == MP_DONE && !mp_we);
   c_mode1_write : cover property (mode_s && mp_state == MP_DONE && mp_we);
   c_serial_done : cover property (acc.done && !acc.we);
   c_collide : cover property (acc.req && (s_rd || s_wr) &&
                               mp_state == MP_IDLE);
endmodule

// ===== tb/dpca_mem_model.sv
// behavioural internal memory on the far side of the register engine
// assumes read data is needed only while rd_in is high
`timescale 1ns/1ps
module dpca_mem_model (
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [9:0]  addr_in,
   input  wire logic [35:0] wdata_in,
   output logic      [35:0] rdata_out
);
   logic [35:0] mem [1024];
   logic        tog = 1'b0;
   always @(posedge clk_in) begin
      tog <= ~tog;
      if (wr_in) mem[addr_in] <= wdata_in;
   end
   // toggling filler outside reads so stale data never passes
   assign rdata_out = rd_in ? mem[addr_in] : {36{tog}};
endmodule

// ===== tb/tb_dual_port_control_access.sv
// self-checking bench for the control-access block
// assumes the internal memory model answers the engine's bus
`timescale 1ns/1ps
module tb_dual_port_control_access;
   logic clk = 1'b0, rst = 1'b1, mode = 1'b0, cs_n = 1'b1;
   logic rd_n = 1'b1, wr_n = 1'b1, cv = 1'b0, fs = 1'b0;
   logic [2:0]  a = 3'h0;
   logic [7:0]  d = 8'h00, q, d_out;
   logic [15:0] cmd = 16'h0000;
   logic d_oe_n, ready, ack_n, sbusy, iwr, ird_en;
   logic [31:0] srd;
   logic [2:0]  sreads;
   logic [9:0]  iaddr;
   logic [35:0] iwd, ird;
   int bad_count = 0, comparisons = 0;
   logic keep = 1'b0;
   dpca_top u_dpca_top (.CORE_CLK_IN(clk), .RST_IN(rst), .MODE_IN(mode),
      .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n), .A_IN(a), .D_IN(d),
      .D_OUT(d_out), .D_OE_N_OUT(d_oe_n), .READY_OUT(ready),
      .TRANSFER_ACK_N_OUT(ack_n), .SERIAL_COMMAND_IN(cmd),
      .SERIAL_COMMAND_VALID_IN(cv), .SERIAL_FRAME_START_IN(fs),
      .SERIAL_RDATA_OUT(srd), .SERIAL_READS_OUT(sreads),
      .SERIAL_BUSY_OUT(sbusy), .INT_ADDR_OUT(iaddr), .INT_WDATA_OUT(iwd),
      .INT_WR_OUT(iwr), .INT_RD_OUT(ird_en), .INT_RDATA_IN(ird));
   dpca_mem_model u_dpca_mem_model (.clk_in(clk), .rd_in(ird_en),
      .wr_in(iwr), .addr_in(iaddr), .wdata_in(iwd), .rdata_out(ird));
   initial forever #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [35:0] s, input logic [35:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one microport access: hold until ready or acknowledge, then release
   task acc(input logic m, input logic r, input logic [2:0] ad,
            input logic [7:0] wd);
      int i;
      @(posedge clk);
      mode <= m; a <= ad; d <= wd; cs_n <= 1'b0; wr_n <= r;
      rd_n <= m ? 1'b0 : ~r;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (i == 0) chk("early answer", m ? ack_n : ready, m);
         if (m ? ack_n === 1'b0 : ready === 1'b1) break;
      end
      if (i == 40) chk("handshake", 36'h0_0000_0000, 36'h0_0000_0001);
      q = d_out;
      chk("drive enable", d_oe_n, !r);
      cs_n <= 1'b1;
      if (!keep) begin
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end
      repeat (6) @(posedge clk);
   endtask
   task ser(input logic [15:0] c);
      int i;
      @(posedge clk);
      cmd <= c; cv <= 1'b1;
      @(posedge clk);
      cmd <= 16'h0000; cv <= 1'b0;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (sbusy === 1'b0) break;
      end
      if (i == 20) chk("serial busy", sbusy, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_write_carry;
      logic [39:0] v;
      int i;
      v = 40'h0A_3322_1144;
      acc(0, 0, 3'h7, 8'hC1);
      acc(0, 0, 3'h6, 8'hFF);
      for (i = 4; i >= 0; i--) acc(0, 0, i[2:0], v[8*i +: 8]);
      chk("mem 1ff", u_dpca_mem_model.mem[10'h1FF], v[35:0]);
      acc(0, 1, 3'h6, 8'h00);
      chk("low addr", q, 8'h00);
      acc(0, 1, 3'h7, 8'h00);
      chk("mode ctrl", q, 8'hC2);
      $display("test write_carry done");
   endtask
   task t_read_wrap;
      logic [39:0] w;
      int i;
      w = 40'h05_8877_6655;
      u_dpca_mem_model.mem[10'h3FF] = w[35:0];
      acc(1, 0, 3'h7, 8'h43);
      acc(1, 0, 3'h6, 8'hFF);
      for (i = 0; i < 5; i++) begin
         acc(1, 1, i[2:0], 8'h00);
         chk("byte", q & (i == 4 ? 8'h0F : 8'hFF), w[8*i +: 8]);
      end
      acc(1, 1, 3'h6, 8'h00);
      chk("low addr", q, 8'h00);
      acc(1, 1, 3'h7, 8'h00);
      chk("mode ctrl", q, 8'h40);
      acc(1, 1, 3'h5, 8'h00);
      chk("reserved", q, 8'h00);
      $display("test read_wrap done");
   endtask
   task t_serial;
      @(posedge clk);
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      ser(16'h415A);
      ser(16'hBBFF);
      ser(16'h8100);
      chk("serial word", srd[31:16], 16'h885A);
      chk("serial reads", sreads, 3'h2);
      acc(0, 1, 3'h1, 8'h00);
      chk("shared byte", q, 8'h5A);
      $display("test serial done");
   endtask
   // serial write request arrives in the cycle the synchronised microport read appears
   task t_collide(input logic m, input logic [7:0] b);
      fork
         acc(m, 1, 3'h2, 8'h00);
         begin
            repeat (3) @(posedge clk);
            ser({8'h42, b});
         end
      join
      chk("collide", q, b);
      $display("test collide done");
   endtask
   task t_held;
      keep = 1'b1;
      acc(0, 0, 3'h6, 8'h5E);
      keep = 1'b0;
      acc(0, 0, 3'h4, 8'h09);
      acc(0, 1, 3'h6, 8'h00);
      chk("held low addr", q, 8'h5E);
      acc(0, 1, 3'h4, 8'h00);
      chk("held byte four", q & 8'h0F, 8'h09);
      $display("test held done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_write_carry();
      t_read_wrap();
      t_serial();
      t_collide(1'b0, 8'h5C);
      t_collide(1'b1, 8'hA7);
      t_held();
      conclude();
   end
endmodule
